// ===== core/ecs_pkg.sv
// package of cycle kinds, state costs and instruction classes for ecs timing
package ecs_pkg;

  // the six kinds of bus cycle an instruction is split into
  typedef enum logic [2:0] {
    ECS_K_FETCH  = 3'h0,
    ECS_K_BRADDR = 3'h1,
    ECS_K_STACK  = 3'h2,
    ECS_K_BYTE   = 3'h3,
    ECS_K_WORD   = 3'h4,
    ECS_K_INTOP  = 3'h5
  } ecs_kind_t;

  localparam int ECS_NUM_KINDS = 6;

  // per-cycle state costs
  localparam logic [1:0] ECS_S_FETCH = 2'h2;     // fetch from on-chip memory
  localparam logic [1:0] ECS_S_BRADDR = 2'h2;    // branch address from rom
  localparam logic [1:0] ECS_S_STACK = 2'h2;     // stack in on-chip ram
  localparam logic [1:0] ECS_S_MEM_DATA = 2'h2;  // data in on-chip ram
  localparam logic [1:0] ECS_S_PERI_FAST = 2'h2; // fast peripheral module
  localparam logic [1:0] ECS_S_PERI_SLOW = 2'h3; // slow peripheral module
  localparam logic [1:0] ECS_S_INTOP = 2'h1;     // internal operation

  // cycle counts per kind, one 2-bit field per kind index
  typedef logic [ECS_NUM_KINDS-1:0][1:0] ecs_cnt_t;

  // instruction classes the core hands over
  typedef enum logic [3:0] {
    ECS_I_ADD_B_IMM = 4'h0, // add byte immediate
    ECS_I_ADD_W_IMM = 4'h1, // add word immediate
    ECS_I_ADD_L_IMM = 4'h2, // add 32-bit immediate into extended reg
    ECS_I_ADD_L_REG = 4'h3, // add long register to register
    ECS_I_AND_L_REG = 4'h4, // and long register to register
    ECS_I_BAND_ABS8 = 4'h5, // bit and from memory, 8-bit absolute
    ECS_I_BCC_D8 = 4'h6,    // conditional branch, 8-bit displacement
    ECS_I_BCC_D16 = 4'h7,   // conditional branch, 16-bit displacement
    ECS_I_BSET_ABS8 = 4'h8, // bit set in memory, read-modify-write
    ECS_I_JSR_IND = 4'h9    // subroutine call through memory vector
  } ecs_instr_t;

  // sequencer states, gray along idle-run-done
  typedef enum logic [1:0] {
    ECS_ST_IDLE = 2'h0,
    ECS_ST_RUN = 2'h1,
    ECS_ST_DONE = 2'h3
  } ecs_state_t;

  localparam int ECS_TOT_W = 8;

endpackage : ecs_pkg

// ===== core/ecs_timing.sv
// execution state timing sequencer for cpu instructions
//
// Function
// - six cycle kinds: fetch, branch read, stack, byte, word, internal
// - total states equal the sum of count times cost over six kinds
// - an instruction fetch from on-chip memory takes two states
// - byte access to on-chip ram takes two states
// - branch address read and stack operation take two states each
// - peripheral data access takes two or three states, by module
// - long immediate add into extended register: three fetches only
// - bit and at 8-bit absolute address is two fetches, one byte access
// - short branch: two fetches, no internal cycle, taken or not
`timescale 1ns/10ps
module ecs_timing
  import ecs_pkg::*;
(
  input wire logic core_clk_i,           // system clock, 100 MHz
  input wire logic reset_n_i,            // async reset, active low
  input wire logic start_i,              // one-cycle request from core
  input wire ecs_instr_t instr_i,        // instruction class
  input wire logic data_periph_i,        // data target is a peripheral
  input wire logic periph_slow_i,        // addressed peripheral needs 3 states
  output logic busy_o,                   // sequence in progress
  output logic cycle_start_o,            // first state of a bus cycle
  output ecs_kind_t cycle_kind_o,        // kind of the current cycle
  output logic done_o,                   // pulse after last state
  output logic [ECS_TOT_W-1:0] total_states_o, // computed total
  output logic [ECS_TOT_W-1:0] elapsed_o // states spent so far
);

  // cycle counts for each class
  function automatic ecs_cnt_t decode_counts(input ecs_instr_t ins);
    ecs_cnt_t c;
    c = '0;
    case (ins)
      ECS_I_ADD_B_IMM: c[ECS_K_FETCH] = 2'h1;
      ECS_I_ADD_W_IMM: c[ECS_K_FETCH] = 2'h2;
      ECS_I_ADD_L_IMM: c[ECS_K_FETCH] = 2'h3;
      ECS_I_ADD_L_REG: c[ECS_K_FETCH] = 2'h1;
      ECS_I_AND_L_REG: c[ECS_K_FETCH] = 2'h2;
      ECS_I_BAND_ABS8: begin
        c[ECS_K_FETCH] = 2'h2;
        c[ECS_K_BYTE] = 2'h1;
      end
      ECS_I_BCC_D8: c[ECS_K_FETCH] = 2'h2;
      ECS_I_BCC_D16: begin
        c[ECS_K_FETCH] = 2'h2;
        c[ECS_K_INTOP] = 2'h2;
      end
      ECS_I_BSET_ABS8: begin
        c[ECS_K_FETCH] = 2'h2;
        c[ECS_K_BYTE] = 2'h2;
      end
      ECS_I_JSR_IND: begin
        c[ECS_K_FETCH] = 2'h2;
        c[ECS_K_BRADDR] = 2'h1;
        c[ECS_K_STACK] = 2'h1;
      end
      default: c[ECS_K_FETCH] = 2'h1; // unknown class: one fetch
    endcase
    return c;
  endfunction : decode_counts

  // states per cycle of a kind
  function automatic logic [1:0] kind_cost(input logic [2:0] k,
                                           input logic periph,
                                           input logic slow);
    logic [1:0] s;
    s = ECS_S_INTOP;
    case (k)
      ECS_K_FETCH: s = ECS_S_FETCH;
      ECS_K_BRADDR: s = ECS_S_BRADDR;
      ECS_K_STACK: s = ECS_S_STACK;
      ECS_K_BYTE, ECS_K_WORD: begin
        if (periph) begin
          s = slow ? ECS_S_PERI_SLOW : ECS_S_PERI_FAST;
        end else begin
          s = ECS_S_MEM_DATA;
        end
      end
      ECS_K_INTOP: s = ECS_S_INTOP;
      default: s = ECS_S_INTOP;
    endcase
    return s;
  endfunction : kind_cost

  // sum of count times cost over all kinds
  function automatic logic [ECS_TOT_W-1:0] sum_states(input ecs_cnt_t c,
                                                      input logic periph,
                                                      input logic slow);
    logic [ECS_TOT_W-1:0] acc;
    acc = '0;
    for (int k = 0; k < ECS_NUM_KINDS; k++) begin
      acc = acc + ECS_TOT_W'(c[k]) *
            ECS_TOT_W'(kind_cost(3'(k), periph, slow));
    end
    return acc;
  endfunction : sum_states

  // first kind with cycles left, in fixed kind order; msb flags found
  function automatic logic [3:0] first_kind(input ecs_cnt_t c);
    logic [3:0] r;
    r = 4'h0;
    for (int k = ECS_NUM_KINDS - 1; k >= 0; k--) begin
      if (c[k] != 2'h0) begin
        r = {1'b1, 3'(k)};
      end
    end
    return r;
  endfunction : first_kind

  ecs_state_t state_ff;
  ecs_cnt_t cnt_ff;
  logic [1:0] left_ff;
  logic periph_ff;
  logic slow_ff;
  ecs_cnt_t req_cnt;
  logic [3:0] req_first;
  ecs_cnt_t nxt_cnt;
  logic [3:0] nxt_first;
  logic start_ok;

  // request-side decode and the counts after the current cycle ends
  always_comb begin
    req_cnt = decode_counts(instr_i);
    req_first = first_kind(req_cnt);
    start_ok = start_i && (state_ff == ECS_ST_IDLE);
    nxt_cnt = cnt_ff;
    nxt_cnt[cycle_kind_o] = cnt_ff[cycle_kind_o] - 2'h1;
    nxt_first = first_kind(nxt_cnt);
  end

  // requests while busy are dropped; the core waits for done_o
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ECS_ST_IDLE;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      case (state_ff)
        ECS_ST_IDLE: begin
          done_o <= 1'b0;
          if (start_ok) begin
            state_ff <= ECS_ST_RUN;
            busy_o <= 1'b1;
          end
        end
        ECS_ST_RUN: begin
          if (left_ff <= 2'h1 && !nxt_first[3]) begin
            state_ff <= ECS_ST_DONE;
            done_o <= 1'b1;
          end
        end
        ECS_ST_DONE: begin
          state_ff <= ECS_ST_IDLE;
          busy_o <= 1'b0;
          done_o <= 1'b0;
        end
        default: begin
          state_ff <= ECS_ST_IDLE;
          busy_o <= 1'b0;
          done_o <= 1'b0;
        end
      endcase
    end
  end

  // access target latched so a mid-sequence change cannot stretch a cycle
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_ff <= 1'b0;
      slow_ff <= 1'b0;
      total_states_o <= '0;
    end else if (start_ok) begin
      periph_ff <= data_periph_i;
      slow_ff <= periph_slow_i;
      total_states_o <= sum_states(req_cnt, data_periph_i,
                                   periph_slow_i);
    end
  end

  // cycle stepping: one state per clock, next kind on cycle end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= '0;
      left_ff <= 2'h0;
      cycle_kind_o <= ECS_K_FETCH;
      cycle_start_o <= 1'b0;
    end else if (start_ok) begin
      cnt_ff <= req_cnt;
      cycle_kind_o <= ecs_kind_t'(req_first[2:0]);
      left_ff <= kind_cost(req_first[2:0], data_periph_i, periph_slow_i);
      cycle_start_o <= 1'b1;
    end else if (state_ff == ECS_ST_RUN) begin
      if (left_ff > 2'h1) begin
        left_ff <= left_ff - 2'h1;
        cycle_start_o <= 1'b0;
      end else begin
        cnt_ff <= nxt_cnt;
        cycle_start_o <= nxt_first[3];
        if (nxt_first[3]) begin
          cycle_kind_o <= ecs_kind_t'(nxt_first[2:0]);
          left_ff <= kind_cost(nxt_first[2:0], periph_ff, slow_ff);
        end
      end
    end else begin
      cycle_start_o <= 1'b0;
    end
  end

  // states spent, compared against the total at the end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      elapsed_o <= '0;
    end else if (start_ok) begin
      elapsed_o <= '0;
    end else if (state_ff == ECS_ST_RUN) begin
      elapsed_o <= elapsed_o + ECS_TOT_W'(1);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence seq_req(ecs_instr_t ins);
    start_i && !busy_o && instr_i == ins && !data_periph_i;
  endsequence

  sequence seq_next_or_end;
    cycle_start_o || done_o;
  endsequence

  AST_ADDL_TOTAL: assert property (
    seq_req(ECS_I_ADD_L_IMM) |=> total_states_o == 8'h06 ##6 done_o)
    else $error("long immediate add timing wrong");

  AST_BAND_TOTAL: assert property (
    seq_req(ECS_I_BAND_ABS8) |=> total_states_o == 8'h06)
    else $error("bit and from ram not six states");

  AST_BCC_TOTAL: assert property (
    seq_req(ECS_I_BCC_D8) |=> total_states_o == 8'h04 ##4 done_o)
    else $error("short branch not four states");

  AST_JSR_TOTAL: assert property (
    seq_req(ECS_I_JSR_IND) |=> total_states_o == 8'h08)
    else $error("indirect call not eight states");

  AST_PERIPH_SLOW: assert property (
    start_i && !busy_o && instr_i == ECS_I_BAND_ABS8 && data_periph_i
    |=> total_states_o == ($past(periph_slow_i) ? 8'h07 : 8'h06))
    else $error("peripheral byte access cost wrong");

  AST_DONE_ELAPSED: assert property (
    $rose(done_o) |-> elapsed_o == total_states_o)
    else $error("elapsed states differ from total");

  AST_FETCH_LEN: assert property (
    cycle_start_o && cycle_kind_o == ECS_K_FETCH
    |=> !cycle_start_o ##1 seq_next_or_end)
    else $error("fetch cycle not two states");

  AST_INTOP_LEN: assert property (
    cycle_start_o && cycle_kind_o == ECS_K_INTOP |=> seq_next_or_end)
    else $error("internal cycle not one state");

  AST_RAM_BYTE_LEN: assert property (
    cycle_start_o && cycle_kind_o == ECS_K_BYTE && !periph_ff
    |=> !cycle_start_o ##1 seq_next_or_end)
    else $error("ram byte access not two states");

  AST_KIND_LEGAL: assert property (
    cycle_start_o |-> cycle_kind_o <= ECS_K_INTOP && busy_o)
    else $error("illegal cycle kind");

endmodule : ecs_timing

// ===== tb/ecs_mem_model.sv
// far-side model: which target takes a data cycle and how fast it is
`timescale 1ns/10ps
module ecs_mem_model #(
  parameter logic [7:0] SLOW_MAP = 8'ha5 // peripherals needing 3 states
) (
  input wire logic [3:0] target_i, // 0-7 on-chip ram, 8-15 peripheral
  output logic data_periph_o, // data cycle goes to a peripheral
  output logic periph_slow_o // that peripheral takes 3 states
);
  // ram always answers in 2 states, peripherals per module
  assign data_periph_o = target_i[3];
  assign periph_slow_o = target_i[3] & SLOW_MAP[target_i[2:0]];
endmodule : ecs_mem_model

// ===== tb/tb.sv
// self-checking bench for the ecs timing sequencer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; \
  if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb import ecs_pkg::*; ();
  localparam logic [7:0] SLOW = 8'ha5;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start_i = 1'b0;
  ecs_instr_t instr_i = ECS_I_ADD_B_IMM;
  logic [3:0] target = 4'h0;
  logic data_periph, periph_slow, busy_o, cycle_start_o, done_o;
  ecs_kind_t cycle_kind_o;
  logic [ECS_TOT_W-1:0] total_states_o, elapsed_o;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'hf152;

  always #5 core_clk_i = ~core_clk_i;

  ecs_mem_model #(.SLOW_MAP(SLOW)) mem_u (.target_i(target),
    .data_periph_o(data_periph), .periph_slow_o(periph_slow));
  ecs_timing dut_u (.core_clk_i, .reset_n_i, .start_i, .instr_i,
    .data_periph_i(data_periph), .periph_slow_i(periph_slow), .busy_o,
    .cycle_start_o, .cycle_kind_o, .done_o, .total_states_o, .elapsed_o);

  // cycles of each kind per class, kind 5 in the top nibble
  function automatic logic [5:0][3:0] kind_cnt(ecs_instr_t ins);
    case (ins)
      ECS_I_ADD_B_IMM, ECS_I_ADD_L_REG: return 24'h000001;
      ECS_I_ADD_W_IMM, ECS_I_AND_L_REG: return 24'h000002;
      ECS_I_BCC_D8: return 24'h000002;
      ECS_I_ADD_L_IMM: return 24'h000003;
      ECS_I_BAND_ABS8: return 24'h001002;
      ECS_I_BCC_D16: return 24'h200002;
      ECS_I_BSET_ABS8: return 24'h002002;
      ECS_I_JSR_IND: return 24'h000112;
      default: return 24'h000001; // unknown class is one fetch
    endcase
  endfunction : kind_cnt

  // states one cycle of a kind costs
  function automatic logic [3:0] kind_cost(int k, logic per, logic slow);
    if (k == 5) return 4'h1;
    if ((k == 3 || k == 4) && per) return slow ? 4'h3 : 4'h2;
    return 4'h2;
  endfunction : kind_cost

  // one instruction; entered and left at a falling edge so runs abut
  task automatic run(ecs_instr_t ins, logic [3:0] tgt, logic poke);
    logic [5:0][3:0] ec, es, oc, os;
    logic [7:0] tot;
    int cyc;
    ecs_kind_t pk;
    ec = kind_cnt(ins);
    tot = 8'h0;
    oc = '0;
    os = '0;
    pk = ECS_K_FETCH;
    for (int k = 0; k < 6; k++) begin
      es[k] = ec[k] * kind_cost(k, tgt[3], tgt[3] & SLOW[tgt[2:0]]);
      tot = tot + 8'(es[k]);
    end
    start_i = 1'b1;
    instr_i = ins;
    target = tgt;
    @(negedge core_clk_i);
    `CHK("total", tot, total_states_o)
    cyc = 1;
    while (done_o !== 1'b1 && cyc < 40) begin
      if (cycle_start_o === 1'b1) oc[cycle_kind_o] += 4'h1;
      os[cycle_kind_o] += 4'h1;
      `CHK("kind_order", 1'b1, cycle_kind_o >= pk)
      `CHK("busy_run", 1'b1, busy_o)
      pk = cycle_kind_o;
      // a stray start and new target mid-run must change nothing
      start_i = poke && cyc == 2;
      if (poke && cyc == 2) begin
        instr_i = ECS_I_JSR_IND;
        target = tgt ^ 4'h8;
      end
      @(negedge core_clk_i);
      cyc++;
    end
    start_i = 1'b0;
    `CHK("done_cycle", tot + 8'h1, 8'(cyc))
    `CHK("elapsed", tot, elapsed_o)
    `CHK("starts", ec, oc)
    `CHK("states", es, os)
    @(negedge core_clk_i);
    `CHK("busy_end", 1'b0, busy_o)
    `CHK("done_pulse", 1'b0, done_o)
  endtask : run

  task print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // hang guard, far above the roughly one thousand cycles the run needs
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(negedge core_clk_i);
    reset_n_i = 1'b1;
    // every class against ram, a slow and a fast peripheral
    for (int i = 0; i < 11; i++) begin
      run(ecs_instr_t'(i), 4'h0, 1'b0);
      run(ecs_instr_t'(i), 4'h8, 1'b1);
      run(ecs_instr_t'(i), 4'h9, 1'b0);
    end
    $display("test directed done");
    for (int i = 0; i < 150; i++)
      run(ecs_instr_t'($random(seed)), 4'($random(seed)),
        1'($random(seed)));
    $display("test random done");
    // reset in mid-run clears everything, then a fresh start
    start_i = 1'b1;
    instr_i = ECS_I_JSR_IND;
    @(negedge core_clk_i);
    start_i = 1'b0;
    @(negedge core_clk_i);
    reset_n_i = 1'b0;
    #1;
    `CHK("rst_busy", 1'b0, busy_o)
    `CHK("rst_total", 8'h0, total_states_o)
    `CHK("rst_cstart", 1'b0, cycle_start_o)
    @(negedge core_clk_i);
    reset_n_i = 1'b1;
    run(ECS_I_BCC_D8, 4'h0, 1'b0);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
